// File: src/cap_cfg.svh
// Constants of the argument and data decoder for complex instructions.
// Assumes a 16-bit instruction word stream and an AXI4-Lite register bus.
`ifndef CAP_CFG_SVH
`define CAP_CFG_SVH

// ----------------------------------------------------------------
// Argument layout
// ----------------------------------------------------------------
`define CAP_ARG_COUNT      16
`define CAP_ARG_TOTAL      36
// Word count per argument, nibble n is argument n
`define CAP_ARG_LEN_TABLE  64'h211c_1122_1422_2111
`define CAP_ARG_LEN_W      4

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define CAP_OP_KIND_LSB    0
`define CAP_OP_KIND_W      3

// ----------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------
`define CAP_REG_CTRL       8'h00
`define CAP_REG_STATUS     8'h04
`define CAP_REG_ARG_SEL    8'h08
`define CAP_REG_ARG_DATA   8'h0c
`define CAP_REG_LAST_FLAGS 8'h10
`define CAP_REG_BYTES_LEFT 8'h14
`define CAP_REG_DONE_COUNT 8'h18
`define CAP_CTRL_ENABLE    0
`define CAP_CTRL_ABORT     1
`define CAP_CTRL_RESET     1'h1
`define CAP_RESP_OKAY      2'h0
`define CAP_RESP_SLVERR    2'h2

`endif

// File: src/cap_pkg.sv
// Types and helper functions of the argument and data decoder.
// Assumes cap_cfg.svh is on the include path.
`include "cap_cfg.svh"

package cap_pkg;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CAP_K_NONE   = 3'b000,
    CAP_K_IMAGE  = 3'b001,
    CAP_K_RASTER = 3'b010,
    CAP_K_TEXT   = 3'b011,
    CAP_K_PLOT   = 3'b100,
    CAP_K_COORD  = 3'b101
  } cap_kind_t;

  typedef enum logic [2:0] {
    CAP_S_OP    = 3'b000,
    CAP_S_FLAGS = 3'b001,
    CAP_S_ARG   = 3'b010,
    CAP_S_LEN   = 3'b011,
    CAP_S_DATA  = 3'b100
  } cap_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    cap_kind_t   kind;
    logic [1:0]  nbytes;
    logic [15:0] data;
  } cap_word_t;

  typedef struct packed {
    cap_kind_t   kind;
    logic [31:0] data;
  } cap_item_t;

  // ----------------------------------------------------------------
  // Argument table lookups
  // ----------------------------------------------------------------
  function automatic logic [3:0] cap_arg_len(input logic [3:0] idx);
    logic [63:0] t;
    t = `CAP_ARG_LEN_TABLE;
    return t[{idx, 2'b00} +: `CAP_ARG_LEN_W];
  endfunction

  function automatic logic [5:0] cap_arg_base(input logic [3:0] idx);
    logic [5:0] s;
    s = 6'h00;
    for (int i = 0; i < `CAP_ARG_COUNT; i++) begin
      if (i < int'(idx)) begin
        s = s + {2'h0, cap_arg_len(4'(i))};
      end
    end
    return s;
  endfunction

  function automatic cap_kind_t cap_decode_kind(input logic [2:0] code);
    cap_kind_t k;
    case (code)
      3'h1:    k = CAP_K_IMAGE;
      3'h2:    k = CAP_K_RASTER;
      3'h3:    k = CAP_K_TEXT;
      3'h4:    k = CAP_K_PLOT;
      3'h5:    k = CAP_K_COORD;
      default: k = CAP_K_NONE;
    endcase
    return k;
  endfunction

endpackage

// File: src/cap_arg_mem.sv
// Argument word store: one write port, one read port with registered data.
// Assumes a single clock; contents are not reset.
`timescale 1ns/1ps
`default_nettype none

module cap_arg_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 36,
  parameter int AW    = 6
) (
  input  wire logic             aclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW) || DEPTH < 1) begin : g_bad_depth
    $error("cap_arg_mem: DEPTH does not fit AW");
  end

  // ----------------------------------------------------------------
  // Write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end

endmodule

`default_nettype wire

// File: src/cap_data_split.sv
// Splits data words into pixel, raster, text, plot or coordinate items.
// Assumes words arrive high byte first; the item sink may stall.
`timescale 1ns/1ps
`default_nettype none

module cap_data_split
  import cap_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      aresetn,
  input  wire cap_word_t in_word,
  input  wire logic      in_valid,
  output logic           in_ready,
  input  wire logic      flush,
  output cap_item_t      out_item,
  output logic           out_valid,
  input  wire logic      out_ready
);

  logic        room;
  logic        take;
  logic        busy;
  logic [15:0] sbuf;
  logic [1:0]  bleft;
  logic [2:0]  bitn;
  cap_kind_t   bkind;
  logic [15:0] half;
  logic        have_half;
  logic        emit;
  logic [15:0] pad_word;

  assign room     = !out_valid || out_ready;
  assign in_ready = !busy && room;
  assign take     = in_valid && in_ready;
  assign emit     = busy && room;
  assign pad_word = (in_word.nbytes == 2'h1) ?
                    {in_word.data[15:8], 8'h00} : in_word.data;

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_item  <= '0;
    end else if (take) begin
      case (in_word.kind)
        CAP_K_IMAGE, CAP_K_PLOT: begin
          out_item  <= {in_word.kind, 16'h0000, pad_word};
          out_valid <= 1'b1;
        end
        CAP_K_COORD: begin
          if (have_half) begin
            out_item  <= {in_word.kind, half, pad_word};
            out_valid <= 1'b1;
          end else begin
            out_valid <= 1'b0;
          end
        end
        default: begin
          out_valid <= 1'b0;
        end
      endcase
    end else if (emit) begin
      out_valid <= 1'b1;
      if (bkind == CAP_K_TEXT) begin
        out_item <= {bkind, 24'h000000, sbuf[15:8]};
      end else begin
        out_item <= {bkind, 31'h00000000, sbuf[15]};
      end
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte and bit engine for text and raster
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy  <= 1'b0;
      sbuf  <= 16'h0000;
      bleft <= 2'h0;
      bitn  <= 3'h0;
      bkind <= CAP_K_NONE;
    end else if (take) begin
      busy  <= (in_word.kind == CAP_K_TEXT) ||
               (in_word.kind == CAP_K_RASTER);
      sbuf  <= in_word.data;
      bleft <= in_word.nbytes;
      bitn  <= 3'h0;
      bkind <= in_word.kind;
    end else if (emit) begin
      if (bkind == CAP_K_TEXT) begin
        sbuf  <= {sbuf[7:0], 8'h00};
        bleft <= bleft - 2'h1;
        busy  <= (bleft != 2'h1);
      end else begin
        sbuf <= {sbuf[14:0], 1'b0};
        bitn <= bitn + 3'h1;
        if (bitn == 3'h7) begin
          bleft <= bleft - 2'h1;
          busy  <= (bleft != 2'h1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // First half of a coordinate pair
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half      <= 16'h0000;
      have_half <= 1'b0;
    end else if (take && in_word.kind == CAP_K_COORD) begin
      half      <= pad_word;
      have_half <= !have_half;
    end else if (flush) begin
      have_half <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: src/cap_top.sv
// Complex instruction argument and data decoder with AXI4-Lite registers.
// Assumes the command word source and item sink share aclk.
`timescale 1ns/1ps
`default_nettype none
`include "cap_cfg.svh"

module cap_top
  import cap_pkg::*;
#(
  parameter int ARG_DEPTH = `CAP_ARG_TOTAL
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] cmd_word,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  output cap_item_t        item,
  output logic             item_valid,
  input  wire logic        item_ready,
  output logic             instr_done
);

  if (ARG_DEPTH < `CAP_ARG_TOTAL || ARG_DEPTH > 64) begin : g_bad_depth
    $error("cap_top: ARG_DEPTH cannot hold the argument words");
  end

  cap_state_t  state;
  cap_kind_t   kind;
  logic [15:0] pend;
  logic [3:0]  wcnt;
  logic [15:0] left;
  logic [15:0] last_flags;
  logic [15:0] done_count;
  logic        enable;
  logic        abort;
  logic [5:0]  arg_sel;
  logic [15:0] arg_q;
  logic [3:0]  cur_arg;
  logic [3:0]  cur_len;
  logic        last_word;
  logic [15:0] next_pend;
  logic        take;
  logic        finish;
  logic        word_ready;
  logic        word_valid;
  cap_word_t   word;
  cap_state_t  after_args;
  logic        mem_we;
  logic [5:0]  mem_waddr;

  // ----------------------------------------------------------------
  // Argument selection
  // ----------------------------------------------------------------
  always_comb begin
    cur_arg = 4'h0;
    for (int i = `CAP_ARG_COUNT - 1; i >= 0; i--) begin
      if (pend[i]) begin
        cur_arg = 4'(i);
      end
    end
  end

  // Word counts per argument
  // and
  assign cur_len    = cap_arg_len(cur_arg);
  assign last_word  = (wcnt == cur_len - 4'h1);
  assign next_pend  = pend & ~(16'h0001 << cur_arg);
  assign after_args = (kind == CAP_K_NONE) ? CAP_S_OP : CAP_S_LEN;

  assign cmd_ready  = enable && ((state != CAP_S_DATA) || word_ready);
  assign take       = cmd_valid && cmd_ready;
  assign word_valid = cmd_valid && enable && (state == CAP_S_DATA);
  assign word.kind  = kind;
  assign word.nbytes = (left > 16'h0001) ? 2'h2 : 2'h1;
  assign word.data  = cmd_word;

  // Only flagged arguments are written; the rest keep their words
  assign mem_we    = take && (state == CAP_S_ARG);
  assign mem_waddr = cap_arg_base(cur_arg) + {2'h0, wcnt};

  always_comb begin
    finish = 1'b0;
    if (take) begin
      case (state)
        CAP_S_FLAGS: finish = (cmd_word == 16'h0000) &&
                              (kind == CAP_K_NONE);
        CAP_S_ARG:   finish = last_word && (next_pend == 16'h0000) &&
                              (kind == CAP_K_NONE);
        CAP_S_LEN:   finish = (cmd_word == 16'h0000);
        CAP_S_DATA:  finish = (left <= 16'h0002);
        default:     finish = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Instruction sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= CAP_S_OP;
      kind       <= CAP_K_NONE;
      pend       <= 16'h0000;
      wcnt       <= 4'h0;
      left       <= 16'h0000;
      last_flags <= 16'h0000;
    end else if (abort) begin
      state <= CAP_S_OP;
      pend  <= 16'h0000;
      wcnt  <= 4'h0;
      left  <= 16'h0000;
    end else if (take) begin
      case (state)
        CAP_S_OP: begin
          kind  <= cap_decode_kind(
                     cmd_word[`CAP_OP_KIND_LSB +: `CAP_OP_KIND_W]);
          state <= CAP_S_FLAGS;
        end
        CAP_S_FLAGS: begin
          pend       <= cmd_word;
          last_flags <= cmd_word;
          wcnt       <= 4'h0;
          state      <= (cmd_word != 16'h0000) ? CAP_S_ARG : after_args;
        end
        CAP_S_ARG: begin
          if (last_word) begin
            wcnt <= 4'h0;
            pend <= next_pend;
            if (next_pend == 16'h0000) begin
              state <= after_args;
            end
          end else begin
            wcnt <= wcnt + 4'h1;
          end
        end
        CAP_S_LEN: begin
          left  <= cmd_word;
          state <= (cmd_word == 16'h0000) ? CAP_S_OP : CAP_S_DATA;
        end
        CAP_S_DATA: begin
          left <= left - {14'h0000, word.nbytes};
          if (left <= 16'h0002) begin
            state <= CAP_S_OP;
          end
        end
        default: begin
          state <= CAP_S_OP;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_done <= 1'b0;
      done_count <= 16'h0000;
    end else begin
      instr_done <= finish && !abort;
      if (finish && !abort) begin
        done_count <= done_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Argument store and data splitter
  // ----------------------------------------------------------------
  cap_arg_mem #(
    .WIDTH (16),
    .DEPTH (ARG_DEPTH),
    .AW    (6)
  ) u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (cmd_word),
    .raddr (arg_sel),
    .rdata (arg_q)
  );

  cap_data_split u_split (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_word   (word),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .flush     (instr_done),
    .out_item  (item),
    .out_valid (item_valid),
    .out_ready (item_ready)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign do_write      = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CAP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          `CAP_REG_CTRL, `CAP_REG_ARG_SEL, `CAP_REG_STATUS,
          `CAP_REG_ARG_DATA, `CAP_REG_LAST_FLAGS, `CAP_REG_BYTES_LEFT,
          `CAP_REG_DONE_COUNT: s_axi_bresp <= `CAP_RESP_OKAY;
          default:             s_axi_bresp <= `CAP_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable  <= `CAP_CTRL_RESET;
      abort   <= 1'b0;
      arg_sel <= 6'h00;
    end else begin
      abort <= 1'b0;
      if (do_write && w_strb[0]) begin
        if (aw_addr == `CAP_REG_CTRL) begin
          enable <= w_data[`CAP_CTRL_ENABLE];
          abort  <= w_data[`CAP_CTRL_ABORT];
        end
        if (aw_addr == `CAP_REG_ARG_SEL) begin
          arg_sel <= w_data[5:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic       ar_pend;
  logic [7:0] ar_addr;

  assign s_axi_arready = !ar_pend && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_pend      <= 1'b0;
      ar_addr      <= 8'h00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CAP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      ar_pend <= 1'b1;
      ar_addr <= s_axi_araddr;
    end else if (ar_pend) begin
      ar_pend      <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `CAP_RESP_OKAY;
      case (ar_addr)
        `CAP_REG_CTRL:       s_axi_rdata <= {31'h0, enable};
        `CAP_REG_STATUS:     s_axi_rdata <= {27'h0, item_valid,
                                             (state != CAP_S_OP), state};
        `CAP_REG_ARG_SEL:    s_axi_rdata <= {26'h0, arg_sel};
        `CAP_REG_ARG_DATA:   s_axi_rdata <= {16'h0, arg_q};
        `CAP_REG_LAST_FLAGS: s_axi_rdata <= {16'h0, last_flags};
        `CAP_REG_BYTES_LEFT: s_axi_rdata <= {16'h0, left};
        `CAP_REG_DONE_COUNT: s_axi_rdata <= {16'h0, done_count};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `CAP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: test/cap_host_model.sv
// Host-side word source for the decoder's command stream.
// Assumes the bench fills q and drives slow to add idle gaps.
`timescale 1ns/1ps
`default_nettype none

module cap_host_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  input  wire logic        cmd_ready,
  output logic      [15:0] cmd_word,
  output logic             cmd_valid
);
  logic [15:0] q[$];

  // Word is held until taken; idle word lines toggle every cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_word <= 16'h0;
      cmd_valid <= 1'b0;
    end else if (!cmd_valid || cmd_ready) begin
      if (q.size() != 0 && !(slow && $urandom_range(1) == 0)) begin
        cmd_word <= q.pop_front();
        cmd_valid <= 1'b1;
      end else begin
        cmd_word <= ~cmd_word;
        cmd_valid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/cap_top_chk.sv
// Concurrent checks on the ports of the decoder's top module.
// Assumes one clock aclk and synchronous active-low aresetn.
`timescale 1ns/1ps
`default_nettype none

module cap_top_chk
  import cap_pkg::*;
(
  input wire logic      aclk,
  input wire logic      aresetn,
  input wire logic      s_axi_awvalid,
  input wire logic      s_axi_awready,
  input wire logic      s_axi_wvalid,
  input wire logic      s_axi_wready,
  input wire logic      s_axi_bvalid,
  input wire logic      s_axi_arvalid,
  input wire logic      s_axi_arready,
  input wire logic      s_axi_rvalid,
  input wire logic      cmd_valid,
  input wire logic      cmd_ready,
  input wire cap_item_t item,
  input wire logic      item_valid,
  input wire logic      item_ready,
  input wire logic      instr_done
);
  logic took;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      took <= 1'b0;
    end else begin
      took <= cmd_valid && cmd_ready;
    end
  end

  sequence item_stall;
    item_valid && !item_ready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_item_hold: assert property (item_stall |=>
    item_valid && $stable(item))
    else $error("item changed while stalled");
  chk_raster_bit: assert property (item_valid &&
    item.kind == CAP_K_RASTER |-> item.data[31:1] == 31'h0)
    else $error("raster item wider than one bit");
  chk_text_byte: assert property (item_valid &&
    item.kind == CAP_K_TEXT |-> item.data[31:8] == 24'h0)
    else $error("text item wider than one byte");
  chk_pixel_word: assert property (item_valid &&
    item.kind == CAP_K_IMAGE |-> item.data[31:16] == 16'h0)
    else $error("pixel item wider than one word");
  chk_plot_word: assert property (item_valid &&
    item.kind == CAP_K_PLOT |-> item.data[31:16] == 16'h0)
    else $error("plot item wider than one word");
  chk_item_kind: assert property (item_valid |->
    item.kind != CAP_K_NONE && item.kind <= CAP_K_COORD)
    else $error("item of no data kind");
  chk_done_take: assert property (instr_done |-> took)
    else $error("done without a word taken");
  chk_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done longer than one cycle");
  chk_write_resp: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_resp: assert property (rd_take |-> ##2 s_axi_rvalid)
    else $error("read response late");
  chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while pending");
endmodule

bind cap_top cap_top_chk i_cap_top_chk (.*);
`default_nettype wire

// File: test/cap_top_tb.sv
// Self-checking bench of the argument and data decoder.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module cap_top_tb
  import cap_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, item_ready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic cmd_valid, cmd_ready, item_valid, instr_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cmd_word;
  cap_item_t item;
  int err_total = 0, checks_done = 0, n_done = 0, exp_done = 0;
  logic [15:0] amem [36];
  cap_item_t exp_q[$];
  int alen[16] = '{1, 1, 1, 2, 2, 2, 4, 1, 2, 2, 1, 1, 12, 1, 1, 2};

  always #50 aclk = ~aclk;

  cap_top i_cap_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .item(item), .item_valid(item_valid),
    .item_ready(item_ready), .instr_done(instr_done));
  cap_host_model i_host (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .cmd_ready(cmd_ready), .cmd_word(cmd_word), .cmd_valid(cmd_valid));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_item(input cap_item_t g, input cap_item_t e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic axi(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic [1:0] rs);
    logic ta, tw, tr, fin;
    @(posedge aclk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (int n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = arvalid && arready;
      fin = wr ? bvalid : rvalid;
      rd = rdata;
      rs = wr ? bresp : rresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) arvalid <= 1'b0;
      if (fin) begin
        bready <= 1'b0;
        rready <= 1'b0;
        return;
      end
    end
    err_total++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic [1:0] r;
    axi(1'b1, a, d, x, r);
    chk_reg({30'h0, r}, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] x;
    logic [1:0] r;
    axi(1'b0, a, 32'h0, x, r);
    chk_reg(x, e);
    chk_reg({30'h0, r}, {30'h0, er});
  endtask

  // ----------------------------------------------------------------
  // Instruction builder and reference model
  // ----------------------------------------------------------------
  task automatic instr(input logic [2:0] k, input logic [15:0] fl,
                       input int len);
    logic [15:0] w;
    logic [7:0] b[$];
    logic [7:0] lo;
    int base;
    cap_kind_t kd;
    base = 0;
    i_host.q.push_back({13'h0, k});
    i_host.q.push_back(fl);
    for (int a = 0; a < 16; a++) begin
      for (int j = 0; j < alen[a] && fl[a]; j++) begin
        w = 16'($urandom);
        amem[base + j] = w;
        i_host.q.push_back(w);
      end
      base += alen[a];
    end
    exp_done++;
    if (k == 3'h0 || k > 3'h5) return;
    kd = cap_kind_t'(k);
    i_host.q.push_back(16'(len));
    for (int i = 0; i <= len; i++) b.push_back(8'($urandom));
    for (int i = 0; i < len; i += 2) i_host.q.push_back({b[i], b[i + 1]});
    for (int i = 0; i < len; i++) begin
      lo = (i + 1 < len) ? b[i + 1] : 8'h00;
      case (kd)
        CAP_K_IMAGE, CAP_K_PLOT: begin
          if (i % 2 == 0) exp_q.push_back({kd, 16'h0, b[i], lo});
        end
        CAP_K_RASTER: begin
          for (int j = 7; j >= 0; j--) exp_q.push_back({kd, 31'h0, b[i][j]});
        end
        CAP_K_TEXT: exp_q.push_back({kd, 24'h0, b[i]});
        default: begin
          if (i % 4 == 0 && i + 3 < len)
            exp_q.push_back({kd, b[i], b[i + 1], b[i + 2], b[i + 3]});
        end
      endcase
    end
  endtask

  task automatic drain();
    for (int n = 0; n < 3000 && (i_host.q.size() != 0 || cmd_valid
         || exp_q.size() != 0); n++) @(posedge aclk);
    repeat (4) @(posedge aclk);
    chk_reg(exp_q.size(), 32'h0);
    chk_reg(n_done, exp_done);
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Monitors, stalls and watchdog
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    item_ready <= $urandom_range(3) != 0;
    slow <= 1'($urandom_range(1));
    if (aresetn && instr_done === 1'b1) n_done++;
    if (aresetn && item_valid === 1'b1 && item_ready)
      chk_item(item, exp_q.size() != 0 ? exp_q.pop_front() : 35'hx);
  end

  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(65973));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h00, 32'h1, 2'h0);
    rd_chk(8'h40, 32'h0, 2'h2);
    instr(3'h0, 16'hffff, 0);
    repeat (3) begin
      instr(3'h6, 16'($urandom), 0);
      for (int k = 1; k <= 5; k++) begin
        instr(3'(k), 16'($urandom),
              k == 5 ? 2 * $urandom_range(1, 6) : $urandom_range(1, 21));
        instr(3'(k), 16'h0, 0);
      end
    end
    drain();
    for (int i = 0; i < 36; i++) begin
      wr(8'h08, 32'(i));
      rd_chk(8'h0c, {16'h0, amem[i]}, 2'h0);
    end
    wr(8'h00, 32'h0);
    instr(3'h0, 16'h0001, 0);
    repeat (20) @(posedge aclk);
    chk_reg(i_host.q.size(), 32'h2);
    wr(8'h00, 32'h1);
    drain();
    rd_chk(8'h18, 32'(exp_done), 2'h0);
    rd_chk(8'h10, 32'h1, 2'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
